// ---- verilog/mbrm_defines.vh ----
// constants of the modbus request mapper
// included by bare name from each design file
// Notes on behaviour
// RULE_01 - fc 01 reads coils: outputs, relays, contacts
// RULE_02 - fc 02 reads inputs and special relays
// RULE_03 - fc 03 reads holding registers, word memory
// RULE_04 - fc 04 reads input registers, word memory; reads holding registers when legacy_mode_i is set
// RULE_05 - fc 05 forces one coil bit
// RULE_06 - fc 06 writes one holding register
// RULE_07 - fc 08 loop back, no memory touched
// RULE_08 - fc 15 forces consecutive coil bits
// RULE_09 - fc 16 writes consecutive holding registers
// RULE_10 - requests served without any controller program
// RULE_11 - address is octal-to-decimal index plus range start
// RULE_12 - discrete types; timer and counter contact ranges
// RULE_13 - address decoded together with data type
// RULE_14 - 256 stage bits at coils 5120-5375
// RULE_15 - 128 timer values at input registers 0-127
// RULE_16 - counter values at input registers 512-639
// RULE_17 - 3072 user words at holding 768-3839
// RULE_18 - word data kept apart from discrete data
// RULE_19 - error: function code msb set, exception code
// RULE_20 - normal answer echoes request function code
// RULE_21 - transaction identifier copied into answer
// RULE_22 - unit identifier returned unchanged
// RULE_23 - bad code or address: exception, no access
`ifndef MBRM_DEFINES_VH
`define MBRM_DEFINES_VH
`define MBRM_FC_RD_COILS   8'h01
`define MBRM_FC_RD_INPUTS  8'h02
`define MBRM_FC_RD_HOLD    8'h03
`define MBRM_FC_RD_INREG   8'h04
`define MBRM_FC_WR_COIL    8'h05
`define MBRM_FC_WR_REG     8'h06
`define MBRM_FC_LOOPBACK   8'h08
`define MBRM_FC_WR_COILS   8'h0F
`define MBRM_FC_WR_REGS    8'h10
`define MBRM_FC_ERR_FLAG   8'h80
`define MBRM_EXC_NONE      8'h00
`define MBRM_EXC_FUNC      8'h01
`define MBRM_EXC_ADDR      8'h02
`define MBRM_EXC_VALUE     8'h03
`define MBRM_EXC_FAIL      8'h04
`define MBRM_COIL_ON       16'hFF00
`define MBRM_COIL_OFF      16'h0000
`define MBRM_LOOP_ECHO     16'h0000
`define MBRM_MAX_RD_BITS   16'h07D0
`define MBRM_MAX_RD_REGS   16'h007D
`define MBRM_MAX_WR_BITS   16'h07B0
`define MBRM_MAX_WR_REGS   16'h007B
`define MBRM_TBL_COIL      2'h0
`define MBRM_TBL_INPUT     2'h1
`define MBRM_TBL_HOLD      2'h2
`define MBRM_TBL_INREG     2'h3
`define MBRM_RG_NONE       4'h0
`define MBRM_RG_OUTPUT     4'h1
`define MBRM_RG_CTRL_RELAY 4'h2
`define MBRM_RG_STAGE      4'h3
`define MBRM_RG_TMR_CONT   4'h4
`define MBRM_RG_CNT_CONT   4'h5
`define MBRM_RG_INPUT      4'h6
`define MBRM_RG_SPEC_RELAY 4'h7
`define MBRM_RG_TMR_VAL    4'h8
`define MBRM_RG_CNT_VAL    4'h9
`define MBRM_RG_USER_WORD  4'hA
`define MBRM_OUT_LO        16'h0800
`define MBRM_OUT_HI        16'h08FF
`define MBRM_CR_LO         16'h0C00
`define MBRM_CR_HI         16'h0DFF
`define MBRM_STG_LO        16'h1400
`define MBRM_STG_HI        16'h14FF
`define MBRM_TC_LO         16'h1800
`define MBRM_TC_HI         16'h187F
`define MBRM_CC_LO         16'h1900
`define MBRM_CC_HI         16'h197F
`define MBRM_TV_LO         16'h0000
`define MBRM_TV_HI         16'h007F
`define MBRM_CV_LO         16'h0200
`define MBRM_CV_HI         16'h027F
`define MBRM_UW_LO         16'h0300
`define MBRM_UW_HI         16'h0EFF
`endif

// ---- verilog/mbrm_addr_map.v ----
// decodes data table and address span to a memory region
// combinational; caller keeps qty_i at one or more
`include "mbrm_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module mbrm_addr_map (
    input  wire [1:0]  tbl_i,    // modbus data table
    input  wire [15:0] addr_i,   // first modbus address
    input  wire [15:0] qty_i,    // item count
    output reg         hit_o,    // whole span inside one region
    output reg  [3:0]  region_o, // controller memory region
    output wire [11:0] offset_o  // decimal index inside region
);
    reg  [15:0] base;
    wire [15:0] diff;

    function in_rng;
        input [15:0] a;
        input [15:0] q;
        input [15:0] lo;
        input [15:0] hi;
        reg   [16:0] last;
        begin
            last   = {1'b0, a} + {1'b0, q} - 17'h00001;
            in_rng = (a >= lo) && (last <= {1'b0, hi});
        end
    endfunction

    assign diff     = addr_i - base;
    assign offset_o = diff[11:0]; // RULE_11

    always @* begin
        region_o = `MBRM_RG_NONE;
        base     = 16'h0000;
        case (tbl_i) // RULE_13
            `MBRM_TBL_COIL: begin // RULE_12
                if (in_rng(addr_i, qty_i, `MBRM_OUT_LO, `MBRM_OUT_HI)) begin
                    region_o = `MBRM_RG_OUTPUT; base = `MBRM_OUT_LO;
                end else if (in_rng(addr_i, qty_i, `MBRM_CR_LO, `MBRM_CR_HI)) begin
                    region_o = `MBRM_RG_CTRL_RELAY; base = `MBRM_CR_LO;
                end else if (in_rng(addr_i, qty_i, `MBRM_STG_LO, `MBRM_STG_HI)) begin
                    region_o = `MBRM_RG_STAGE; base = `MBRM_STG_LO; // RULE_14
                end else if (in_rng(addr_i, qty_i, `MBRM_TC_LO, `MBRM_TC_HI)) begin
                    region_o = `MBRM_RG_TMR_CONT; base = `MBRM_TC_LO;
                end else if (in_rng(addr_i, qty_i, `MBRM_CC_LO, `MBRM_CC_HI)) begin
                    region_o = `MBRM_RG_CNT_CONT; base = `MBRM_CC_LO;
                end
            end
            `MBRM_TBL_INPUT: begin
                if (in_rng(addr_i, qty_i, `MBRM_OUT_LO, `MBRM_OUT_HI)) begin
                    region_o = `MBRM_RG_INPUT; base = `MBRM_OUT_LO;
                end else if (in_rng(addr_i, qty_i, `MBRM_CR_LO, `MBRM_CR_HI)) begin
                    region_o = `MBRM_RG_SPEC_RELAY; base = `MBRM_CR_LO;
                end
            end
            `MBRM_TBL_INREG: begin // RULE_18
                if (in_rng(addr_i, qty_i, `MBRM_TV_LO, `MBRM_TV_HI)) begin
                    region_o = `MBRM_RG_TMR_VAL; base = `MBRM_TV_LO; // RULE_15
                end else if (in_rng(addr_i, qty_i, `MBRM_CV_LO, `MBRM_CV_HI)) begin
                    region_o = `MBRM_RG_CNT_VAL; base = `MBRM_CV_LO; // RULE_16
                end
            end
            default: begin
                if (in_rng(addr_i, qty_i, `MBRM_UW_LO, `MBRM_UW_HI)) begin
                    region_o = `MBRM_RG_USER_WORD; base = `MBRM_UW_LO; // RULE_17
                end
            end
        endcase
        hit_o = (region_o != `MBRM_RG_NONE);
    end
endmodule // mbrm_addr_map
`default_nettype wire

// ---- verilog/mbrm_request_mapper.v ----
// modbus server request interpreter mapping requests onto memory
// assumes an outside framer and a memory port on the same clock
`include "mbrm_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module mbrm_request_mapper (
    input  wire        clk_i,         // 50 MHz clock
    input  wire        nrst_i,        // async reset, active low
    input  wire        legacy_mode_i, // legacy addressing mode pin
    input  wire        req_valid_i,   // request fields valid
    output wire        req_ready_o,   // request taken
    input  wire [15:0] req_tid_i,     // transaction identifier
    input  wire [7:0]  req_unit_i,    // unit identifier
    input  wire [7:0]  req_fc_i,      // function code
    input  wire [15:0] req_addr_i,    // start address / subfunction
    input  wire [15:0] req_field2_i,  // quantity, value or echo data
    input  wire        wr_valid_i,    // write item valid
    output wire        wr_ready_o,    // write item taken
    input  wire [15:0] wr_data_i,     // write item, coil in bit 0
    output wire        rd_valid_o,    // read item valid
    input  wire        rd_ready_i,    // read item taken
    output reg  [15:0] rd_data_o,     // read item, coil in bit 0
    output wire        rsp_valid_o,   // answer valid
    input  wire        rsp_ready_i,   // answer taken
    output reg  [15:0] rsp_tid_o,     // echoed transaction id
    output reg  [7:0]  rsp_unit_o,    // echoed unit id
    output reg  [7:0]  rsp_fc_o,      // answer function code
    output reg  [7:0]  rsp_exc_o,     // exception code, 0 if none
    output reg  [15:0] rsp_addr_o,    // echoed address field
    output reg  [15:0] rsp_field2_o,  // echoed second field
    output reg  [15:0] rsp_count_o,   // items moved
    output reg         mem_req_o,     // memory access request
    output reg         mem_we_o,      // memory write
    output reg  [3:0]  mem_region_o,  // memory region
    output reg  [11:0] mem_index_o,   // decimal index in region
    output reg  [15:0] mem_wdata_o,   // write data, coil in bit 0
    input  wire        mem_ack_i,     // access done
    input  wire        mem_err_i,     // access failed, with ack
    input  wire [15:0] mem_rdata_i    // read data with ack
);
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_CHECK = 3'h1;
    localparam [2:0] S_NEXT  = 3'h2;
    localparam [2:0] S_WDATA = 3'h3;
    localparam [2:0] S_WAIT  = 3'h4;
    localparam [2:0] S_OUT   = 3'h5;
    localparam [2:0] S_RESP  = 3'h6;

    reg  [2:0]  st;
    reg  [7:0]  fc;
    reg  [15:0] addr;
    reg  [15:0] f2;
    reg  [15:0] cnt;
    reg  [15:0] idx;
    reg  [3:0]  region;
    reg  [11:0] offset;
    reg         is_wr;
    reg         multi_wr;
    reg         legacy_s1;
    reg         legacy;
    reg  [1:0]  tbl;
    reg         fc_ok;
    reg  [15:0] max_qty;
    wire [15:0] map_qty;
    wire        map_hit;
    wire [3:0]  map_region;
    wire [11:0] map_offset;
    wire [15:0] item_index;
    wire        single;

    // pin is asynchronous to the clock
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            legacy_s1 <= 1'b0;
            legacy    <= 1'b0;
        end else begin
            legacy_s1 <= legacy_mode_i;
            legacy    <= legacy_s1;
        end
    end

    assign single = (fc == `MBRM_FC_WR_COIL) || (fc == `MBRM_FC_WR_REG);
    assign map_qty = single ? 16'h0001 : f2;

    // function code to table, count limit and support
    always @* begin
        tbl     = `MBRM_TBL_HOLD;
        max_qty = 16'h0001;
        fc_ok   = 1'b1;
        case (fc)
            `MBRM_FC_RD_COILS: begin // RULE_01
                tbl     = `MBRM_TBL_COIL;
                max_qty = `MBRM_MAX_RD_BITS;
            end
            `MBRM_FC_RD_INPUTS: begin // RULE_02
                tbl     = `MBRM_TBL_INPUT;
                max_qty = `MBRM_MAX_RD_BITS;
            end
            `MBRM_FC_RD_HOLD: begin // RULE_03
                max_qty = `MBRM_MAX_RD_REGS;
            end
            `MBRM_FC_RD_INREG: begin // RULE_04
                tbl     = legacy ? `MBRM_TBL_HOLD : `MBRM_TBL_INREG;
                max_qty = `MBRM_MAX_RD_REGS;
            end
            `MBRM_FC_WR_COIL: begin // RULE_05
                tbl = `MBRM_TBL_COIL;
            end
            `MBRM_FC_WR_REG: begin // RULE_06
            end
            `MBRM_FC_WR_COILS: begin // RULE_08
                tbl     = `MBRM_TBL_COIL;
                max_qty = `MBRM_MAX_WR_BITS;
            end
            `MBRM_FC_WR_REGS: begin // RULE_09
                tbl     = `MBRM_TBL_HOLD;
                max_qty = `MBRM_MAX_WR_REGS;
            end
            `MBRM_FC_LOOPBACK: begin
            end
            default: begin
                fc_ok = 1'b0; // RULE_23
            end
        endcase
    end

    mbrm_addr_map u_map (
        .tbl_i    (tbl),
        .addr_i   (addr),
        .qty_i    (map_qty),
        .hit_o    (map_hit),
        .region_o (map_region),
        .offset_o (map_offset)
    );

    assign req_ready_o = (st == S_IDLE);
    assign wr_ready_o  = (st == S_WDATA);
    assign rd_valid_o  = (st == S_OUT);
    assign rsp_valid_o = (st == S_RESP);
    assign item_index  = {4'h0, offset} + idx;

    // main sequence, no controller program needed
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st           <= S_IDLE;
            fc           <= 8'h00;
            addr         <= 16'h0000;
            f2           <= 16'h0000;
            cnt          <= 16'h0000;
            idx          <= 16'h0000;
            region       <= `MBRM_RG_NONE;
            offset       <= 12'h000;
            is_wr        <= 1'b0;
            multi_wr     <= 1'b0;
            rd_data_o    <= 16'h0000;
            rsp_tid_o    <= 16'h0000;
            rsp_unit_o   <= 8'h00;
            rsp_fc_o     <= 8'h00;
            rsp_exc_o    <= `MBRM_EXC_NONE;
            rsp_addr_o   <= 16'h0000;
            rsp_field2_o <= 16'h0000;
            rsp_count_o  <= 16'h0000;
            mem_req_o    <= 1'b0;
            mem_we_o     <= 1'b0;
            mem_region_o <= `MBRM_RG_NONE;
            mem_index_o  <= 12'h000;
            mem_wdata_o  <= 16'h0000;
        end else begin
            case (st)
                S_IDLE: begin
                    if (req_valid_i) begin
                        fc           <= req_fc_i;
                        addr         <= req_addr_i;
                        f2           <= req_field2_i;
                        rsp_tid_o    <= req_tid_i;    // RULE_21
                        rsp_unit_o   <= req_unit_i;   // RULE_22
                        rsp_addr_o   <= req_addr_i;
                        rsp_field2_o <= req_field2_i;
                        rsp_exc_o    <= `MBRM_EXC_NONE;
                        rsp_count_o  <= 16'h0000;
                        idx          <= 16'h0000;
                        st           <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    rsp_fc_o <= fc | `MBRM_FC_ERR_FLAG; // RULE_19
                    st       <= S_RESP;
                    if (!fc_ok) begin
                        rsp_exc_o <= `MBRM_EXC_FUNC; // RULE_23
                    end else if (fc == `MBRM_FC_LOOPBACK) begin
                        if (addr == `MBRM_LOOP_ECHO) begin
                            rsp_fc_o <= fc; // RULE_07
                        end else begin
                            rsp_exc_o <= `MBRM_EXC_FUNC;
                        end
                    end else if (!single && (f2 == 16'h0000 || f2 > max_qty)) begin
                        rsp_exc_o <= `MBRM_EXC_VALUE;
                    end else if (fc == `MBRM_FC_WR_COIL
                                 && f2 != `MBRM_COIL_ON && f2 != `MBRM_COIL_OFF) begin
                        rsp_exc_o <= `MBRM_EXC_VALUE;
                    end else if (!map_hit) begin
                        rsp_exc_o <= `MBRM_EXC_ADDR; // RULE_23
                    end else begin
                        region   <= map_region;
                        offset   <= map_offset;
                        cnt      <= map_qty;
                        is_wr    <= single || (fc == `MBRM_FC_WR_COILS)
                                    || (fc == `MBRM_FC_WR_REGS);
                        multi_wr <= (fc == `MBRM_FC_WR_COILS) || (fc == `MBRM_FC_WR_REGS);
                        st       <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    if (idx >= cnt) begin
                        rsp_fc_o    <= fc; // RULE_20
                        rsp_count_o <= cnt;
                        st          <= S_RESP;
                    end else if (multi_wr) begin
                        st <= S_WDATA;
                    end else begin
                        mem_req_o    <= 1'b1; // RULE_10
                        mem_we_o     <= is_wr;
                        mem_region_o <= region;
                        mem_index_o  <= item_index[11:0];
                        if (fc == `MBRM_FC_WR_COIL) begin
                            mem_wdata_o <= {15'h0000, f2 == `MBRM_COIL_ON}; // RULE_05
                        end else begin
                            mem_wdata_o <= f2; // RULE_06
                        end
                        st <= S_WAIT;
                    end
                end
                S_WDATA: begin
                    if (wr_valid_i) begin
                        mem_req_o    <= 1'b1;
                        mem_we_o     <= 1'b1;
                        mem_region_o <= region;
                        mem_index_o  <= item_index[11:0];
                        if (fc == `MBRM_FC_WR_COILS) begin
                            mem_wdata_o <= {15'h0000, wr_data_i[0]}; // RULE_08
                        end else begin
                            mem_wdata_o <= wr_data_i; // RULE_09
                        end
                        st <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o  <= 1'b0;
                        idx       <= idx + 16'h0001;
                        if (mem_err_i) begin
                            rsp_fc_o    <= fc | `MBRM_FC_ERR_FLAG;
                            rsp_exc_o   <= `MBRM_EXC_FAIL;
                            rsp_count_o <= idx;
                            st          <= S_RESP;
                        end else if (is_wr) begin
                            st <= S_NEXT;
                        end else begin
                            if (tbl == `MBRM_TBL_COIL || tbl == `MBRM_TBL_INPUT) begin
                                rd_data_o <= {15'h0000, mem_rdata_i[0]}; // RULE_18
                            end else begin
                                rd_data_o <= mem_rdata_i;
                            end
                            st <= S_OUT;
                        end
                    end
                end
                S_OUT: begin
                    if (rd_ready_i) begin
                        st <= S_NEXT;
                    end
                end
                S_RESP: begin
                    if (rsp_ready_i) begin
                        st <= S_IDLE;
                    end
                end
                default: begin
                    st <= S_IDLE;
                end
            endcase
        end
    end
endmodule // mbrm_request_mapper
`default_nettype wire

// ---- verif/mbrm_asserts.sv ----
// checker of the mapper's answer and memory ports
// bound to every mapper instance below
`timescale 1ns/1ps
`default_nettype none
module mbrm_asserts (
    input wire logic        clk_i,        // clock
    input wire logic        nrst_i,       // reset, active low
    input wire logic        req_valid_i,  // request valid
    input wire logic        req_ready_o,  // request taken
    input wire logic [15:0] req_tid_i,    // transaction id
    input wire logic [7:0]  req_unit_i,   // unit id
    input wire logic [7:0]  req_fc_i,     // function code
    input wire logic        rsp_valid_o,  // answer valid
    input wire logic        rsp_ready_i,  // answer taken
    input wire logic [15:0] rsp_tid_o,    // answer transaction id
    input wire logic [7:0]  rsp_unit_o,   // answer unit id
    input wire logic [7:0]  rsp_fc_o,     // answer function code
    input wire logic [7:0]  rsp_exc_o,    // exception code
    input wire logic        mem_req_o,    // memory request
    input wire logic [3:0]  mem_region_o, // memory region
    input wire logic [11:0] mem_index_o,  // index in region
    input wire logic        mem_ack_i     // memory done
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire         take = req_valid_i && req_ready_o;
    logic [15:0] tid;
    logic [7:0]  unit;
    logic [7:0]  fc;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tid  <= 16'h0000;
            unit <= 8'h00;
            fc   <= 8'h00;
        end else if (take) begin
            tid  <= req_tid_i;
            unit <= req_unit_i;
            fc   <= req_fc_i;
        end
    end
    sequence take_bad_s;
        take && req_fc_i == 8'h07;
    endsequence
    sequence func_exc_s;
        rsp_valid_o && rsp_exc_o == 8'h01 && rsp_fc_o == 8'h87;
    endsequence
    bad_func_a: assert property (take_bad_s |-> ##2 func_exc_s)
        else $error("bad code not refused");
    exc_msb_a: assert property (rsp_valid_o && rsp_exc_o != 8'h00 |-> rsp_fc_o == (fc | 8'h80))
        else $error("exception without msb");
    echo_fc_a: assert property (rsp_valid_o && rsp_exc_o == 8'h00 |-> rsp_fc_o == fc)
        else $error("answer code differs");
    echo_tid_a: assert property (rsp_valid_o |-> rsp_tid_o == tid)
        else $error("tid not copied");
    echo_unit_a: assert property (rsp_valid_o |-> rsp_unit_o == unit)
        else $error("unit id differs");
    rsp_hold_a: assert property (rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_fc_o))
        else $error("answer dropped early");
    loop_nomem_a: assert property (mem_req_o |-> fc != 8'h08 && mem_region_o != 4'h0)
        else $error("bad memory region");
    word_split_a: assert property (mem_req_o && fc inside {8'h03, 8'h04, 8'h06, 8'h10} |-> mem_region_o >= 4'h8)
        else $error("word code hit bit region");
    coil_kind_a: assert property (mem_req_o && fc inside {8'h01, 8'h05, 8'h0F} |-> mem_region_o inside {[4'h1:4'h5]})
        else $error("coil code hit other region");
    user_span_a: assert property (mem_req_o && mem_region_o == 4'hA |-> mem_index_o < 12'd3072)
        else $error("user index out of range");
    mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_index_o))
        else $error("memory request moved");
endmodule // mbrm_asserts
bind mbrm_request_mapper mbrm_asserts mbrm_asserts_i (.*);
`default_nettype wire

// ---- verif/mbrm_mem_model.sv ----
// controller memory model behind the mapper
// answers after slow_i extra cycles, failed if fail_i
`timescale 1ns/1ps
`default_nettype none
module mbrm_mem_model (
    input  wire logic        clk_i,    // clock
    input  wire logic        nrst_i,   // reset, active low
    input  wire logic [3:0]  slow_i,   // extra answer delay
    input  wire logic        fail_i,   // answer with failure
    input  wire logic        req_i,    // access request
    input  wire logic        we_i,     // write
    input  wire logic [3:0]  region_i, // region
    input  wire logic [11:0] index_i,  // index in region
    input  wire logic [15:0] wdata_i,  // write data
    output var  logic        ack_o,    // access done
    output var  logic        err_o,    // access failed
    output var  logic [15:0] rdata_o   // read data
);
    logic [15:0] mem [0:65535];
    logic [3:0]  wait_cnt;
    // each cell starts as its own region and index
    initial for (int k = 0; k < 65536; k++) mem[k] = k[15:0];
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_o    <= 1'b0;
            err_o    <= 1'b0;
            rdata_o  <= 16'hA5A5;
            wait_cnt <= 4'h0;
        end else begin
            ack_o   <= 1'b0;
            err_o   <= 1'b0;
            rdata_o <= ~rdata_o;
            if (req_i && !ack_o) begin
                if (wait_cnt == slow_i) begin
                    ack_o    <= 1'b1;
                    err_o    <= fail_i;
                    wait_cnt <= 4'h0;
                    rdata_o  <= mem[{region_i, index_i}];
                    if (we_i && !fail_i) mem[{region_i, index_i}] <= wdata_i;
                end else wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule // mbrm_mem_model
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench of the request mapper
// assumes design, checker and memory model compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_i = 1'b0, nrst_i = 1'b0, legacy_mode_i = 1'b0, fail = 1'b0;
    logic        req_valid_i = 1'b0, wr_valid_i = 1'b0, rd_ready_i = 1'b0, rsp_ready_i = 1'b0;
    logic [15:0] req_tid_i = 16'h0000, req_addr_i = 16'h0000, req_field2_i = 16'h0000;
    logic [15:0] wr_data_i = 16'h0000, rd_data_o, rsp_tid_o, rsp_addr_o, rsp_field2_o;
    logic [15:0] rsp_count_o, mem_wdata_o, mem_rdata_i;
    logic [7:0]  req_unit_i = 8'h00, req_fc_i = 8'h00, rsp_unit_o, rsp_fc_o, rsp_exc_o;
    logic [3:0]  slow = 4'h0, mem_region_o;
    logic [11:0] mem_index_o;
    logic        req_ready_o, wr_ready_o, rd_valid_o, rsp_valid_o, mem_req_o, mem_we_o;
    logic        mem_ack_i, mem_err_i;
    logic [15:0] rdq[$], none[$];
    int          num_errors = 0, samples_checked = 0, cycles = 0;
    mbrm_request_mapper mbrm_request_mapper_i (.*);
    mbrm_mem_model mbrm_mem_model_i (.clk_i, .nrst_i, .slow_i(slow), .fail_i(fail),
        .req_i(mem_req_o), .we_i(mem_we_o), .region_i(mem_region_o), .index_i(mem_index_o),
        .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .err_o(mem_err_i), .rdata_o(mem_rdata_i));
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        rd_ready_i <= nrst_i && !rd_ready_i;
        if (wr_valid_i && wr_ready_o) wr_data_i <= wr_data_i + 16'h0001;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    always @(negedge clk_i) if (rd_valid_o && rd_ready_i) rdq.push_back(rd_data_o);
    task automatic end_sim();
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] fc, input logic [15:0] adr, input logic [15:0] f2,
                        input logic [7:0] exc, input logic [15:0] exp[$]);
        int n;
        logic [15:0] cnt;
        @(posedge clk_i);
        req_valid_i  <= 1'b1;
        req_fc_i     <= fc;
        req_addr_i   <= adr;
        req_field2_i <= f2;
        req_tid_i    <= req_tid_i + 16'h0103;
        req_unit_i   <= req_unit_i ^ 8'h5A;
        n = 0;
        do begin @(negedge clk_i); n++; end while (!req_ready_o && n < 100);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        n = 0;
        do begin @(negedge clk_i); n++; end while (!rsp_valid_o && n < 500);
        chk(rsp_tid_o, req_tid_i);
        chk(rsp_unit_o, req_unit_i);
        chk(rsp_fc_o, (exc != 8'h00) ? (fc | 8'h80) : fc);
        chk(rsp_exc_o, exc);
        chk(rsp_field2_o, f2);
        chk(rsp_addr_o, adr);
        cnt = (fc == 8'h05 || fc == 8'h06) ? 16'h0001 : f2;
        if (exc != 8'h00 || fc == 8'h08) cnt = 16'h0000;
        chk(rsp_count_o, cnt);
        chk(16'(rdq.size()), 16'(exp.size()));
        foreach (exp[i]) if (i < rdq.size()) chk(rdq[i], exp[i]);
        rdq.delete();
        @(posedge clk_i) rsp_ready_i <= 1'b1;
        @(posedge clk_i) rsp_ready_i <= 1'b0;
    endtask
    task automatic sc_words();
        xfer(8'h06, 16'd3839, 16'h1234, 8'h00, none);
        @(posedge clk_i) wr_data_i <= 16'h1230;
        xfer(8'h10, 16'd768, 16'h0003, 8'h00, none);
        xfer(8'h03, 16'd768, 16'h0003, 8'h00, '{16'h1230, 16'h1231, 16'h1232});
        xfer(8'h03, 16'd3839, 16'h0001, 8'h00, '{16'h1234});
        xfer(8'h03, 16'd3839, 16'h0002, 8'h02, none);
        xfer(8'h04, 16'd127, 16'h0001, 8'h00, '{16'h807F});
        xfer(8'h04, 16'd512, 16'h0001, 8'h00, '{16'h9000});
        xfer(8'h04, 16'd640, 16'h0001, 8'h02, none);
    endtask
    task automatic sc_bits();
        xfer(8'h05, 16'd2303, 16'h0000, 8'h00, none);
        xfer(8'h01, 16'd2303, 16'h0001, 8'h00, '{16'h0000});
        @(posedge clk_i) wr_data_i <= 16'h0006;
        xfer(8'h0F, 16'd6144, 16'h0004, 8'h00, none);
        xfer(8'h01, 16'd6144, 16'h0004, 8'h00, '{0, 1, 0, 1});
        xfer(8'h01, 16'd5375, 16'h0001, 8'h00, '{16'h0001});
        xfer(8'h02, 16'd3072, 16'h0002, 8'h00, '{0, 1});
        xfer(8'h02, 16'd2053, 16'h0001, 8'h00, '{16'h0001});
        xfer(8'h05, 16'd2048, 16'h1234, 8'h03, none);
        xfer(8'h01, 16'd6272, 16'h0001, 8'h02, none);
    endtask
    task automatic sc_misc();
        xfer(8'h08, 16'h0000, 16'hBEEF, 8'h00, none);
        xfer(8'h08, 16'h0001, 16'hBEEF, 8'h01, none);
        xfer(8'h07, 16'd768, 16'h0001, 8'h01, none);
        xfer(8'h11, 16'd768, 16'h0001, 8'h01, none);
        xfer(8'h04, 16'd800, 16'h0001, 8'h02, none);
        @(posedge clk_i) legacy_mode_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        xfer(8'h04, 16'd800, 16'h0001, 8'h00, '{16'hA020});
        @(posedge clk_i) legacy_mode_i <= 1'b0;
        slow <= 4'h3;
        xfer(8'h03, 16'd800, 16'h0002, 8'h00, '{16'hA020, 16'hA021});
        @(posedge clk_i) fail <= 1'b1;
        xfer(8'h03, 16'd800, 16'h0002, 8'h04, none);
        @(posedge clk_i) fail <= 1'b0;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i     <= 1'b1;
        wr_valid_i <= 1'b1;
        sc_words();
        sc_bits();
        sc_misc();
        end_sim();
    end
endmodule // testbench
`default_nettype wire
